// ==== common/cdrid_pkg.sv ====
// Shared constants for the identification and summary register bank
package cdrid_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_IRQ_SUMMARY = 8'h01;
	localparam logic [7:0] ADDR_PART_HIGH   = 8'h02;
	localparam logic [7:0] ADDR_PART_LOW    = 8'h03;
	localparam logic [7:0] ADDR_STEP_HIGH   = 8'h04;
	localparam logic [7:0] ADDR_STEP_LOW    = 8'h05;
	// Reset and fixed values
	localparam logic [7:0] SUMMARY_RESET    = 8'h00;
	localparam logic [7:0] STEP_HIGH_VALUE  = 8'h00;
	localparam logic [7:0] UNMAPPED_VALUE   = 8'h00;
	// Field layout of the summary register
	localparam int         CHAN_COUNT       = 4;
endpackage : cdrid_pkg

// ==== design/cdrid_regs.sv ====
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Per-channel summary bits D0 to D3
// - Summary bits D7 to D4 read zero
// - Part code high then low byte
// - Revision high byte always zero
// - Revision low byte names silicon step
module cdrid_regs #(
	// Part code, arbitrary neutral value
	parameter logic [15:0] PART_CODE = 16'h1234,
	// Silicon step code, arbitrary neutral value
	parameter logic [7:0]  STEP_CODE = 8'h0a
) (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	// Per-channel pending status flags from the channel registers
	input  wire logic [3:0] lol_status,
	input  wire logic [3:0] los_status,
	// Per-channel interrupt enables from the channel registers
	input  wire logic [3:0] lol_enable,
	input  wire logic [3:0] los_enable,
	output logic [3:0]      chan_event_summary
);

	logic [3:0] summary_d;   // Next summary bits
	logic [3:0] summary_q;   // Registered summary bits
	logic [7:0] rdata_d;     // Next read data
	logic [7:0] rdata_q;     // Read data, valid one cycle after strobe

	// Value shown for offsets outside the bank and between reads
	localparam logic [7:0] UNMAPPED_VALUE_L = cdrid_pkg::UNMAPPED_VALUE;

	// Timing seen by software: a read strobe at one edge puts its byte
	// on reg_rdata for exactly the next cycle, then the port drops back
	// to zero. The summary byte is the registered copy, so it trails the
	// channel flags by two edges when read.

	// Writes land nowhere: every register here is read only.
	// The strobe and data are folded into one unread net so that the
	// ports stay in the list for a later writable bank.
	logic       unused_wr;
	assign unused_wr = reg_wr ^ (^reg_wdata);

	// Summary next value: a channel pends while any enabled flag is up
	always_comb begin
		summary_d = (lol_status & lol_enable) | (los_status & los_enable);
	end

	// Read mux; gives zero except in the cycle a read strobe is high
	always_comb begin
		rdata_d = UNMAPPED_VALUE_L;
		if (reg_rd) begin
			unique case (reg_addr)
				cdrid_pkg::ADDR_IRQ_SUMMARY: rdata_d = {4'h0, summary_q};
				cdrid_pkg::ADDR_PART_HIGH:   rdata_d = PART_CODE[15:8];
				cdrid_pkg::ADDR_PART_LOW:    rdata_d = PART_CODE[7:0];
				cdrid_pkg::ADDR_STEP_HIGH:   rdata_d = cdrid_pkg::STEP_HIGH_VALUE;
				cdrid_pkg::ADDR_STEP_LOW:    rdata_d = STEP_CODE;
				// Unmapped offsets read zero
				default:                     rdata_d = UNMAPPED_VALUE_L;
			endcase
		end
	end

	// Registers; summary is registered to give software a stable value
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			// Reset: summary empty, read port quiet
			summary_q <= cdrid_pkg::SUMMARY_RESET[3:0];
			rdata_q   <= UNMAPPED_VALUE_L;
		end else begin
			// Normal run: take the next values
			summary_q <= summary_d;
			rdata_q   <= rdata_d;
		end
	end

	// Both outputs come straight from flip-flops, so neither glitches
	// while the flags or the address settle
	assign reg_rdata          = rdata_q;
	assign chan_event_summary = summary_q;

	// Checks below watch only what this block drives; the flags and the
	// bus are taken as given, since no rule here limits them

	// Summary follows enabled flags one cycle later
	property p_summary_follow;
		@(posedge core_clk) disable iff (rst)
		1'b1 |=> (summary_q == $past(summary_d));
	endproperty
	a_summary_follow: assert property (p_summary_follow)
		else $error("summary does not follow enabled flags");

	// Summary read shows summary bits with zero upper nibble
	property p_summary_read;
		@(posedge core_clk) disable iff (rst)
		(reg_rd && reg_addr == cdrid_pkg::ADDR_IRQ_SUMMARY)
			|=> (reg_rdata == {4'h0, $past(summary_q)});
	endproperty
	a_summary_read: assert property (p_summary_read)
		else $error("summary read value wrong");

	property p_upper_zero;
		@(posedge core_clk) disable iff (rst)
		(reg_rd && reg_addr == cdrid_pkg::ADDR_IRQ_SUMMARY)
			|=> (reg_rdata[7:4] == 4'h0);
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("summary upper bits not zero");

	// Part code bytes in order
	sequence s_rd_part_high;
		reg_rd && reg_addr == cdrid_pkg::ADDR_PART_HIGH;
	endsequence
	property p_part_code;
		@(posedge core_clk) disable iff (rst)
		s_rd_part_high |=> (reg_rdata == PART_CODE[15:8]);
	endproperty
	a_part_code: assert property (p_part_code)
		else $error("part code high byte wrong");

	property p_part_low;
		@(posedge core_clk) disable iff (rst)
		(reg_rd && reg_addr == cdrid_pkg::ADDR_PART_LOW)
			|=> (reg_rdata == PART_CODE[7:0]);
	endproperty
	a_part_low: assert property (p_part_low)
		else $error("part code low byte wrong");

	property p_step_high;
		@(posedge core_clk) disable iff (rst)
		(reg_rd && reg_addr == cdrid_pkg::ADDR_STEP_HIGH)
			|=> (reg_rdata == 8'h00);
	endproperty
	a_step_high: assert property (p_step_high)
		else $error("revision high byte not zero");

	property p_step_low;
		@(posedge core_clk) disable iff (rst)
		(reg_rd && reg_addr == cdrid_pkg::ADDR_STEP_LOW)
			|=> (reg_rdata == STEP_CODE);
	endproperty
	a_step_low: assert property (p_step_low)
		else $error("revision low byte wrong");

	// Read data falls back to zero once its one cycle is over; a stale
	// byte left on the port would let software see a read twice
	sequence s_no_read;
		!reg_rd;
	endsequence
	property p_rdata_idle;
		@(posedge core_clk) disable iff (rst)
		s_no_read |=> (reg_rdata == UNMAPPED_VALUE_L);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside read cycle");

	// Offsets outside the bank, below 0x01 or above 0x05, read zero
	property p_unmapped_zero;
		@(posedge core_clk) disable iff (rst)
		(reg_rd && (reg_addr < cdrid_pkg::ADDR_IRQ_SUMMARY
			|| reg_addr > cdrid_pkg::ADDR_STEP_LOW))
			|=> (reg_rdata == UNMAPPED_VALUE_L);
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero)
		else $error("unmapped offset read not zero");

	// Writes are dropped: a write alone never puts data on the read port
	property p_write_ignored;
		@(posedge core_clk) disable iff (rst)
		(reg_wr && !reg_rd) |=> (reg_rdata == UNMAPPED_VALUE_L);
	endproperty
	a_write_ignored: assert property (p_write_ignored)
		else $error("write changed read data");

	// Summary clears as soon as no enabled flag is left; it is a level,
	// not a sticky latch, so software need not clear it itself
	property p_summary_clear;
		@(posedge core_clk) disable iff (rst)
		(summary_d == 4'h0) |=> (chan_event_summary == 4'h0);
	endproperty
	a_summary_clear: assert property (p_summary_clear)
		else $error("summary did not clear");

	// A masked flag never reaches its summary bit
	property p_summary_masked;
		@(posedge core_clk) disable iff (rst)
		((lol_enable | los_enable) == 4'h0) |=> (summary_q == 4'h0);
	endproperty
	a_summary_masked: assert property (p_summary_masked)
		else $error("masked flag reached summary");

	// Any enabled pending flag shows up in the summary
	property p_summary_any;
		@(posedge core_clk) disable iff (rst)
		(summary_d != 4'h0) |=> (summary_q != 4'h0);
	endproperty
	a_summary_any: assert property (p_summary_any)
		else $error("pending channel missing from summary");

	// Summary holds still while its inputs hold still
	property p_summary_stable;
		@(posedge core_clk) disable iff (rst)
		(summary_d == summary_q) |=> $stable(summary_q);
	endproperty
	a_summary_stable: assert property (p_summary_stable)
		else $error("summary changed without cause");

endmodule : cdrid_regs
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// Compare two values, count it, report a mismatch at once
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
	fails++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
	localparam logic [15:0] PART = 16'h1234; // Arbitrary part code
	localparam logic [7:0]  STEP = 8'h0a;    // Arbitrary step code
	logic       core_clk, rst, reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
	logic [3:0] lol_status, los_status, lol_enable, los_enable, sum;
	int         fails = 0;
	int         checks_done = 0;
	cdrid_regs #(.PART_CODE(PART), .STEP_CODE(STEP)) u_cdrid_regs (
		.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .lol_status(lol_status),
		.los_status(los_status), .lol_enable(lol_enable),
		.los_enable(los_enable), .chan_event_summary(sum));
	// Free running 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// One read cycle; data is taken in the single cycle it stands
	task rd_reg(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask : rd_reg
	// Identity bytes, ignored write, unmapped place
	task t_ident;
		@(posedge core_clk);
		reg_addr <= cdrid_pkg::ADDR_PART_HIGH;
		reg_wdata <= 8'hff;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		rd_reg(8'h02); `CHK("part_hi", PART[15:8], rd)
		rd_reg(8'h03); `CHK("part_lo", PART[7:0], rd)
		rd_reg(8'h04); `CHK("step_hi", 8'h00, rd)
		rd_reg(8'h05); `CHK("step_lo", STEP, rd)
		rd_reg(8'h06); `CHK("unmapped", 8'h00, rd)
		$display("t_ident done");
	endtask : t_ident
	// Summary follows enabled flags only, upper bits stay zero
	task t_summary;
		@(posedge core_clk);
		lol_status <= 4'h5;
		lol_enable <= 4'h7;
		los_status <= 4'ha;
		los_enable <= 4'h8;
		repeat (2) @(posedge core_clk);
		#1 `CHK("summary", 4'hd, sum)
		rd_reg(8'h01); `CHK("irq_reg", 8'h0d, rd)
		@(posedge core_clk);
		lol_enable <= 4'h0;
		los_enable <= 4'h0;
		repeat (2) @(posedge core_clk);
		#1 `CHK("masked", 4'h0, sum)
		rd_reg(8'h01); `CHK("irq_zero", 8'h00, rd)
		$display("t_summary done");
	endtask : t_summary
	// Verdict and end of run
	task finish_test;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	// Hang guard, far beyond the real run
	initial begin
		#200000;
		fails++;
		finish_test();
	end
	// Main sequence
	initial begin
		{rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 18'h0};
		{lol_status, los_status, lol_enable, los_enable} = 16'h0;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		t_ident();
		t_summary();
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
